// File: rtl/rrpg_defines.svh
/*
 Timing constants for the resume reset and power-good generator.
 Assumes a 250 MHz system clock; counts derive from times in ms.
*/
`ifndef RRPG_DEFINES_SVH
`define RRPG_DEFINES_SVH
// ==========================================================
// Clock and timing
`define RRPG_CLK_MHZ 250
`define RRPG_RELEASE_DELAY_MS 350
`define RRPG_PG_SHORT_MS 200
`define RRPG_PG_LONG_MS 500
`define RRPG_ASSERT_DELAY_NS 100
`define RRPG_MS_CYCLES(ms) ((ms) * 1000 * `RRPG_CLK_MHZ)
`define RRPG_RELEASE_CYCLES `RRPG_MS_CYCLES(`RRPG_RELEASE_DELAY_MS)
`define RRPG_PG_SHORT_CYCLES `RRPG_MS_CYCLES(`RRPG_PG_SHORT_MS)
`define RRPG_PG_LONG_CYCLES `RRPG_MS_CYCLES(`RRPG_PG_LONG_MS)
// Strap level that selects the short delay (left at default)
`define RRPG_STRAP_SHORT 1'b0
`endif

// File: rtl/rrpg_pkg.sv
/*
 Types for the resume reset and power-good generator.
 Assumes nothing beyond the defines header.
*/
package rrpg_pkg;
    // ==========================================================
    // Sequencer states
    typedef enum logic [1:0] {
        RRPG_HOLD,
        RRPG_COUNT,
        RRPG_DONE
    } rrpg_state_t;
endpackage

// File: rtl/rrpg_delay.sv
/*
 Qualified delay: done rises once arm has stood for limit cycles.
 Assumes arm and limit are synchronous to clk_sys.
*/
module rrpg_delay
    import rrpg_pkg::*;
#(
    parameter int WIDTH = 28
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic arm,
    input wire logic [WIDTH-1:0] limit,
    output logic done
);
    // The compare against limit - 2 needs at least two counter bits
    if (WIDTH < 2) begin : g_bad_width
        $error("rrpg_delay: WIDTH too small");
    end

    rrpg_state_t state;
    rrpg_state_t next_state;
    logic [WIDTH-1:0] count;
    logic [WIDTH-1:0] next_count;

    // ==========================================================
    // Counter sequencer; any drop of arm restarts from zero
    always_comb begin
        next_state = state;
        next_count = count;
        case (state)
            RRPG_HOLD: begin
                next_count = '0;
                if (arm) begin
                    next_state = RRPG_COUNT;
                end
            end
            RRPG_COUNT: begin
                if (!arm) begin
                    next_state = RRPG_HOLD;
                    next_count = '0;
                end else if (count >= limit - WIDTH'(2)) begin
                    next_state = RRPG_DONE;
                end else begin
                    next_count = count + WIDTH'(1);
                end
            end
            RRPG_DONE: begin
                if (!arm) begin
                    next_state = RRPG_HOLD;
                    next_count = '0;
                end
            end
            default: begin
                next_state = RRPG_HOLD;
                next_count = '0;
            end
        endcase
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            state <= RRPG_HOLD;
            count <= '0;
        end else begin
            state <= next_state;
            count <= next_count;
        end
    end

    // Drop of arm clears done combinationally, so falls add no latency
    assign done = (state == RRPG_DONE) && arm;
endmodule

// File: rtl/rrpg_top.sv
/*
 Resume-well reset and power-good generator.
 Assumes supply comparator outputs, the supply-on request and the strap
 are already synchronous to clk_sys (250 MHz).
*/
// How it works
// - Resume reset released after 350 ms standby good
// - Standby dip restarts full release delay
// - Standby drop asserts reset within 100 ns
// - Power good rises after selected delay
// - Strap at power-up picks delay, default 200ms
// - Supply-on request low with both mains good starts power-good delay
`include "rrpg_defines.svh"
module rrpg_top
    import rrpg_pkg::*;
#(
    parameter int RELEASE_CYCLES = `RRPG_RELEASE_CYCLES,
    parameter int PG_SHORT_CYCLES = `RRPG_PG_SHORT_CYCLES,
    parameter int PG_LONG_CYCLES = `RRPG_PG_LONG_CYCLES
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic standby_above_trip,
    input wire logic main33_above_trip,
    input wire logic main5_above_trip,
    input wire logic supply_on_request_n,
    input wire logic delay_strap,
    output logic resume_well_reset_n,
    output logic power_good_out
);
    localparam int CW = 28;

    // Counts below 2 would underflow the compare in the delay counter
    if (RELEASE_CYCLES < 2) begin : g_bad_release
        $error("rrpg_top: RELEASE_CYCLES must be at least 2");
    end
    if (PG_SHORT_CYCLES < 2) begin : g_bad_short
        $error("rrpg_top: PG_SHORT_CYCLES must be at least 2");
    end
    if (PG_LONG_CYCLES < 2) begin : g_bad_long
        $error("rrpg_top: PG_LONG_CYCLES must be at least 2");
    end
    // All delays share one CW-bit counter width
    if (RELEASE_CYCLES >= (1 << CW)) begin : g_wide_release
        $error("rrpg_top: RELEASE_CYCLES exceeds counter width");
    end
    if (PG_SHORT_CYCLES >= (1 << CW)) begin : g_wide_short
        $error("rrpg_top: PG_SHORT_CYCLES exceeds counter width");
    end
    if (PG_LONG_CYCLES >= (1 << CW)) begin : g_wide_long
        $error("rrpg_top: PG_LONG_CYCLES exceeds counter width");
    end

    // ==========================================================
    // Strap capture after reset release
    // Read once only: later moves of the strap pin wait for the next reset
    logic strap_taken;
    logic next_strap_taken;
    logic strap_long;
    logic next_strap_long;

    always_comb begin
        next_strap_taken = 1'b1;
        next_strap_long = strap_long;
        if (!strap_taken) begin
            next_strap_long = (delay_strap != `RRPG_STRAP_SHORT);
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            strap_taken <= 1'b0;
            strap_long <= 1'b0;
        end else begin
            strap_taken <= next_strap_taken;
            strap_long <= next_strap_long;
        end
    end

    // ==========================================================
    // Resume-well reset
    logic resume_done;

    // Arm drops with the comparator, which restarts the full delay
    rrpg_delay #(.WIDTH(CW)) u_resume (
        .clk_sys(clk_sys),
        .reset(reset),
        .arm(standby_above_trip),
        .limit(CW'(RELEASE_CYCLES)),
        .done(resume_done)
    );

    // Combinational fall meets the 100 ns bound with no cycle spent
    assign resume_well_reset_n = resume_done;

    // ==========================================================
    // Power good
    logic pg_arm;
    logic pg_done;
    logic [CW-1:0] pg_limit;

    // Waits for strap capture so the first count uses the right delay
    assign pg_arm = strap_taken && main33_above_trip && main5_above_trip
        && !supply_on_request_n;
    assign pg_limit = strap_long ? CW'(PG_LONG_CYCLES) : CW'(PG_SHORT_CYCLES);

    rrpg_delay #(.WIDTH(CW)) u_pgood (
        .clk_sys(clk_sys),
        .reset(reset),
        .arm(pg_arm),
        .limit(pg_limit),
        .done(pg_done)
    );

    assign power_good_out = pg_done;

    // ==========================================================
    // Checks
    // Helper counters saturate so a long run cannot wrap them back to zero
    logic [CW-1:0] up_cnt;
    logic [CW-1:0] next_up_cnt;
    logic [CW-1:0] pg_cnt;
    logic [CW-1:0] next_pg_cnt;

    always_comb begin
        next_up_cnt = '0;
        next_pg_cnt = '0;
        if (standby_above_trip) begin
            next_up_cnt = (up_cnt == '1) ? up_cnt : up_cnt + CW'(1);
        end
        if (pg_arm) begin
            next_pg_cnt = (pg_cnt == '1) ? pg_cnt : pg_cnt + CW'(1);
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            up_cnt <= '0;
            pg_cnt <= '0;
        end else begin
            up_cnt <= next_up_cnt;
            pg_cnt <= next_pg_cnt;
        end
    end

    release_early_a: assert property (
        @(posedge clk_sys) disable iff (reset)
        resume_well_reset_n |-> up_cnt >= CW'(RELEASE_CYCLES - 1))
        else $error("resume reset released early");

    release_late_a: assert property (
        @(posedge clk_sys) disable iff (reset)
        (standby_above_trip && up_cnt == CW'(RELEASE_CYCLES)) |-> resume_well_reset_n)
        else $error("resume reset released late");

    release_stays_a: assert property (
        @(posedge clk_sys) disable iff (reset)
        resume_well_reset_n |=> resume_well_reset_n || !standby_above_trip)
        else $error("resume reset fell with standby good");

    out_in_reset_a: assert property (
        @(posedge clk_sys)
        reset |-> !resume_well_reset_n && !power_good_out)
        else $error("outputs active during reset");

    dip_restart_a: assert property (
        @(posedge clk_sys) disable iff (reset)
        (!standby_above_trip ##1 standby_above_trip) |-> !resume_well_reset_n [*2])
        else $error("dip did not restart delay");

    reset_fall_a: assert property (
        @(posedge clk_sys) disable iff (reset)
        !standby_above_trip |-> !resume_well_reset_n)
        else $error("resume reset not asserted at once");

    pg_early_a: assert property (
        @(posedge clk_sys) disable iff (reset)
        power_good_out |-> pg_cnt >= (strap_long ? CW'(PG_LONG_CYCLES - 1)
                                                 : CW'(PG_SHORT_CYCLES - 1)))
        else $error("power good rose early");

    pg_stays_a: assert property (
        @(posedge clk_sys) disable iff (reset)
        power_good_out |=> power_good_out || !pg_arm)
        else $error("power good fell with supplies good");

    pg_late_a: assert property (
        @(posedge clk_sys) disable iff (reset)
        (pg_arm && pg_cnt == (strap_long ? CW'(PG_LONG_CYCLES) : CW'(PG_SHORT_CYCLES)))
        |-> power_good_out)
        else $error("power good rose late");

    strap_hold_a: assert property (
        @(posedge clk_sys) disable iff (reset)
        strap_taken |=> $stable(strap_long))
        else $error("strap selection changed");

    strap_pick_a: assert property (
        @(posedge clk_sys) disable iff (reset)
        !strap_taken |=> strap_long == ($past(delay_strap) != `RRPG_STRAP_SHORT))
        else $error("strap level not captured");

    strap_keep_a: assert property (
        @(posedge clk_sys) disable iff (reset)
        strap_taken |=> strap_taken)
        else $error("strap capture lost");

    pg_wait_strap_a: assert property (
        @(posedge clk_sys) disable iff (reset)
        !strap_taken |-> !power_good_out)
        else $error("power good before strap capture");

    pg_drop_a: assert property (
        @(posedge clk_sys) disable iff (reset)
        (supply_on_request_n || !main33_above_trip || !main5_above_trip)
        |-> !power_good_out)
        else $error("power good not dropped at once");

    pg_restart_a: assert property (
        @(posedge clk_sys) disable iff (reset)
        (!pg_arm ##1 pg_arm) |-> !power_good_out [*2])
        else $error("power good delay not restarted");
endmodule

// File: tb/rrpg_supply_model.sv
/*
 Supply side model: standby and main supply comparators.
 Assumes the bench commands each supply on or off at a clock edge.
*/
module rrpg_supply_model (
    input wire logic standby_on,
    input wire logic [1:0] mains_on,
    output logic standby_above_trip,
    output logic main33_above_trip,
    output logic main5_above_trip
);
    timeunit 1ns;
    timeprecision 100ps;
    // ==========================================================
    // Comparators
    // Ideal comparators with no lag, so any lag at the outputs is the design's
    assign standby_above_trip = standby_on;
    assign main33_above_trip = mains_on[0];
    assign main5_above_trip = mains_on[1];
endmodule

// File: tb/resume_reset_and_power_good_gen_tb_top.sv
/*
 Self-checking bench for the resume reset and power-good generator.
 Assumes short delay parameters in place of the real millisecond counts.
*/
module resume_reset_and_power_good_gen_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int REL = 20;
    localparam int PGS = 10;
    localparam int PGL = 25;
    typedef struct {logic strap; logic req_last; int wait_cyc;} rrpg_row_t;
    // ==========================================================
    // Signals and instances
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic standby_on = 1'b0;
    logic [1:0] mains_on = 2'b00;
    logic supply_on_request_n = 1'b1;
    logic delay_strap = 1'b0;
    wire logic standby_above_trip, main33_above_trip, main5_above_trip;
    wire logic resume_well_reset_n, power_good_out;
    int err_total = 0;
    int samples_checked = 0;
    int cyc = 0;
    rrpg_row_t rows[4] = '{'{1'b0, 1'b0, PGS}, '{1'b0, 1'b1, PGS},
        '{1'b1, 1'b0, PGL}, '{1'b1, 1'b1, PGL}};
    always #2 clk_sys = ~clk_sys;
    rrpg_supply_model i_supply (.standby_on(standby_on), .mains_on(mains_on),
        .standby_above_trip(standby_above_trip), .main33_above_trip(main33_above_trip),
        .main5_above_trip(main5_above_trip));
    rrpg_top #(.RELEASE_CYCLES(REL), .PG_SHORT_CYCLES(PGS), .PG_LONG_CYCLES(PGL)) i_dut (
        .clk_sys(clk_sys), .reset(reset), .standby_above_trip(standby_above_trip),
        .main33_above_trip(main33_above_trip), .main5_above_trip(main5_above_trip),
        .supply_on_request_n(supply_on_request_n), .delay_strap(delay_strap),
        .resume_well_reset_n(resume_well_reset_n), .power_good_out(power_good_out));
    // ==========================================================
    // Tasks
    task automatic check(input string what, input logic seen, input logic exp);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %b seen %b", what, exp, seen);
        end
    endtask
    task automatic tally_and_finish;
        if (err_total == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic do_reset(input logic strap);
        @(posedge clk_sys);
        reset <= 1'b1;
        standby_on <= 1'b0;
        mains_on <= 2'b00;
        supply_on_request_n <= 1'b1;
        delay_strap <= strap;
        repeat (8) @(posedge clk_sys);
        reset <= 1'b0;
    endtask
    // Counts edges until the chosen output rises; one cycle of slack either way
    task automatic time_rise(input string what, input bit pg, input int n);
        int k;
        for (k = 1; k <= n + 2; k++) begin
            @(posedge clk_sys);
            #1;
            if ((pg ? power_good_out : resume_well_reset_n) === 1'b1) break;
        end
        check(what, k >= n - 1 && k <= n + 1, 1'b1);
    endtask
    // ==========================================================
    // Timeout and main sequence
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 3000) begin
            err_total++;
            tally_and_finish();
        end
    end
    initial begin
        foreach (rows[i]) begin
            do_reset(rows[i].strap);
            @(posedge clk_sys);
            standby_on <= 1'b1;
            time_rise("resume release", 0, REL);
            @(posedge clk_sys);
            if (rows[i].req_last) mains_on <= 2'b11;
            else supply_on_request_n <= 1'b0;
            repeat (30) @(posedge clk_sys);
            #1 check("pg half armed", power_good_out, 1'b0);
            @(posedge clk_sys);
            if (rows[i].req_last) supply_on_request_n <= 1'b0;
            else mains_on <= 2'b11;
            time_rise("pg delay", 1, rows[i].wait_cyc);
        end
        for (int j = 0; j < 3; j++) begin
            @(posedge clk_sys);
            // Strap moves after capture; restarts must keep the long delay
            delay_strap <= 1'b0;
            if (j < 2) mains_on <= ~(2'b01 << j);
            else supply_on_request_n <= 1'b1;
            #1 check("pg drop", power_good_out, 1'b0);
            @(posedge clk_sys);
            mains_on <= 2'b11;
            supply_on_request_n <= 1'b0;
            time_rise("pg restart", 1, PGL);
        end
        @(posedge clk_sys);
        standby_on <= 1'b0;
        #1 check("reset assert", resume_well_reset_n, 1'b0);
        @(posedge clk_sys);
        standby_on <= 1'b1;
        repeat (REL / 2) @(posedge clk_sys);
        standby_on <= 1'b0;
        @(posedge clk_sys);
        standby_on <= 1'b1;
        time_rise("glitch restart", 0, REL);
        @(posedge clk_sys);
        reset <= 1'b1;
        #1 check("reset mid run", resume_well_reset_n | power_good_out, 1'b0);
        tally_and_finish();
    end
endmodule
